/* rtl/swt_transmitter.sv */
// Functional notes
// - load buffer, then set enable bit to start; enable low keeps transmitter off
// - mode pin and parity bit pick 8-bit or 32-bit mode and parity
// - with parity, bit 32 becomes odd parity, else loaded data
// - self test holds both serial lines low
// - master reset initialises logic and control word to 8-bit enabled
// - idle output falls when sending starts, rises when word completes
// - ready output high only when buffer accepts data; host writes then
// - zero line pulses for 0 bits, one line for 1 bits, never both
// - both lines low whenever no bit is signalled
// - status bit 0 is 1 when buffer may be loaded
// - status bits 0, 2, 7 mirror ready, idle and error
// - underwrite error only in 8-bit mode, never in 32-bit mode
// - error stays until status read or master reset
// - transmitter suspended while error flag set
// - 8-bit byte write drops ready and idle; they rise later
// - word written as four bytes, bit 1 on data line 0 first
// - underwrite when next byte missing after previous byte's 8th bit
// - clear-to-send high holds off a loaded, enabled word
// - select high for control write and status read, low for data
// - bit timing from 4x transmit clock input
`timescale 1ns/1ps
`default_nettype none
module swt_transmitter (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic TX_BIT_CLOCK_4X,
   input wire logic WORD_MODE_PIN,
   input wire logic SEND_HOLD,
   input wire logic CHIP_SELECT_N,
   input wire logic WRITE_STROBE_N,
   input wire logic READ_STROBE_N,
   input wire logic CMD_DATA_SEL,
   input wire logic [7:0] DATA_IN,
   output logic [7:0] DATA_OUT,
   output logic DATA_OE,
   output logic TX_READY_OUT,
   output logic TX_IDLE_OUT,
   output logic ERROR_FLAG_OUT,
   output logic ZERO_LINE_OUT,
   output logic ONE_LINE_OUT
);
   logic [7:0] ctrl_reg;
   logic [31:0] word_reg;
   logic [2:0] count_reg, count_next;
   logic err_reg, err_next;
   logic ready_reg;
   logic idle_reg;
   logic txc_reg;
   logic ctrl_wr;
   logic data_wr;
   logic rd_end;
   logic rd_active;
   logic ser_busy;
   logic ser_can_start;
   logic bit_end;
   logic done;
   logic [4:0] bit_idx;
   logic [7:0] status_word;

   wire tick = TX_BIT_CLOCK_4X & ~txc_reg;
   wire tx_enable = ctrl_reg[swt_pkg::CTRL_ENABLE_BIT];
   wire self_test = ctrl_reg[swt_pkg::CTRL_TEST_BIT];
   wire par_bit = ctrl_reg[swt_pkg::CTRL_PARITY_BIT];
   wire mode32 = swt_pkg::word_mode32(WORD_MODE_PIN, par_bit);
   wire parity_en = swt_pkg::parity_on(WORD_MODE_PIN, par_bit);
   wire [2:0] cur_byte = {1'b0, bit_idx[4:3]};
   wire [2:0] next_byte = cur_byte + 3'h1;

   // 8-bit mode: free once the byte in flight is the newest one loaded
   wire ready8 = ser_busy ? (count_reg == next_byte) : (count_reg == 3'h0);
   wire ready32 = ~ser_busy & (count_reg != swt_pkg::FULL_COUNT);
   wire ready_next = ~err_reg & (count_reg != swt_pkg::FULL_COUNT)
                     & (mode32 ? ready32 : ready8);
   wire write_ok = data_wr & ready_reg;

   // the word needs all four bytes in 32-bit mode, only the first in 8-bit mode
   wire have_data = mode32 ? (count_reg == swt_pkg::FULL_COUNT) : (count_reg != 3'h0);
   wire start_go = ser_can_start & have_data & tx_enable & ~SEND_HOLD
                   & ~err_reg;

   // a byte's last bit ended while its successor is still missing
   wire underwrite = ~mode32 & bit_end & (bit_idx[2:0] == swt_pkg::LAST_BIT_IN_BYTE)
                     & (bit_idx != swt_pkg::LAST_BIT_IDX)
                     & (count_reg <= next_byte);

   // bit 32 is computed on the fly so late 8-bit loads still count
   wire odd_parity = ~^word_reg[30:0];
   wire cur_bit = (bit_idx == swt_pkg::LAST_BIT_IDX && parity_en) ? odd_parity
                  : word_reg[bit_idx];

   // idle stays low from the first 8-bit byte until the word is out
   wire idle_next = ~ser_busy & ~start_go & (mode32 | (count_reg == 3'h0));

   assign status_word = {ERROR_FLAG_OUT, 4'h0, TX_IDLE_OUT, 1'b0, TX_READY_OUT};
   assign TX_READY_OUT = ready_reg;
   assign TX_IDLE_OUT = idle_reg;
   assign ERROR_FLAG_OUT = err_reg;

   always_comb begin
      count_next = count_reg;
      if (done || underwrite) begin
         count_next = 3'h0;
      end else if (write_ok) begin
         count_next = count_reg + 3'h1;
      end
   end

   // set wins over the clear from a status read
   assign err_next = underwrite | (err_reg & ~rd_end);

   swt_host_port u_port (
      .clk(REF_CLK),
      .rst(RESET),
      .cs_n(CHIP_SELECT_N),
      .we_n(WRITE_STROBE_N),
      .re_n(READ_STROBE_N),
      .cmd_sel(CMD_DATA_SEL),
      .status(status_word),
      .ctrl_wr(ctrl_wr),
      .data_wr(data_wr),
      .rd_end(rd_end),
      .rd_active(rd_active),
      .d_out(DATA_OUT),
      .d_oe(DATA_OE)
   );

   swt_serializer u_ser (
      .clk(REF_CLK),
      .rst(RESET),
      .tick(tick),
      .start(start_go),
      .abort(underwrite),
      .cur_bit(cur_bit),
      .quiet(self_test),
      .busy(ser_busy),
      .ready_to_start(ser_can_start),
      .bit_end(bit_end),
      .done(done),
      .bit_idx(bit_idx),
      .zero_line(ZERO_LINE_OUT),
      .one_line(ONE_LINE_OUT)
   );

   // one lane per byte; byte n holds word bits 8n+1..8n+8
   genvar g;
   generate
      for (g = 0; g < swt_pkg::WORD_BYTES; g++) begin : g_lane
         always_ff @(posedge REF_CLK) begin
            if (RESET) begin
               word_reg[g*8 +: 8] <= 8'h00;
            end else if (write_ok && count_reg == 3'(g)) begin
               word_reg[g*8 +: 8] <= DATA_IN;
            end
         end
      end
   endgenerate

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         ctrl_reg <= swt_pkg::CTRL_RESET_VALUE;
      end else if (ctrl_wr) begin
         ctrl_reg <= DATA_IN;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         txc_reg <= 1'b0;
         count_reg <= 3'h0;
         err_reg <= 1'b0;
         ready_reg <= 1'b0;
         idle_reg <= 1'b1;
      end else begin
         txc_reg <= TX_BIT_CLOCK_4X;
         count_reg <= count_next;
         err_reg <= err_next;
         // a fresh error must drop ready in the same edge that raises the flag
         ready_reg <= ready_next & ~write_ok & ~err_next;
         idle_reg <= idle_next & ~(write_ok & ~mode32);
      end
   end

   sequence s_start;
      start_go;
   endsequence

   sequence s_byte_taken;
      write_ok && !mode32 && !done && !underwrite;
   endsequence

   property p_lines_exclusive;
      @(posedge REF_CLK) disable iff (RESET) !(ZERO_LINE_OUT && ONE_LINE_OUT);
   endproperty
   a_lines_exclusive: assert property (p_lines_exclusive)
      else $error("both serial lines high");

   property p_null_when_quiet;
      @(posedge REF_CLK) disable iff (RESET)
         (!ser_busy || self_test) |=> (!ZERO_LINE_OUT && !ONE_LINE_OUT);
   endproperty
   a_null_when_quiet: assert property (p_null_when_quiet)
      else $error("line driven while not signalling");

   property p_selftest_low;
      @(posedge REF_CLK) disable iff (RESET)
         self_test [*2] |-> (!ZERO_LINE_OUT && !ONE_LINE_OUT);
   endproperty
   a_selftest_low: assert property (p_selftest_low)
      else $error("line driven in self test");

   property p_reset_ctrl;
      @(posedge REF_CLK) RESET |=> (ctrl_reg == swt_pkg::CTRL_RESET_VALUE) && !ERROR_FLAG_OUT;
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl)
      else $error("control word not at reset value");

   property p_idle_falls;
      @(posedge REF_CLK) disable iff (RESET) s_start |-> ##2 !TX_IDLE_OUT;
   endproperty
   a_idle_falls: assert property (p_idle_falls)
      else $error("idle did not fall after start");

   property p_byte_drops;
      @(posedge REF_CLK) disable iff (RESET)
         s_byte_taken |=> (!TX_READY_OUT && !TX_IDLE_OUT);
   endproperty
   a_byte_drops: assert property (p_byte_drops)
      else $error("ready or idle high after byte write");

   property p_status_mirror;
      @(posedge REF_CLK) disable iff (RESET)
         rd_active |=> (DATA_OUT[0] == $past(TX_READY_OUT)) && (DATA_OUT[2] == $past(TX_IDLE_OUT))
                       && (DATA_OUT[7] == $past(ERROR_FLAG_OUT));
   endproperty
   a_status_mirror: assert property (p_status_mirror)
      else $error("status bits do not mirror outputs");

   property p_err_hold;
      @(posedge REF_CLK) disable iff (RESET) (ERROR_FLAG_OUT && !rd_end) |=> ERROR_FLAG_OUT;
   endproperty
   a_err_hold: assert property (p_err_hold)
      else $error("error flag dropped without read");

   property p_err_clear;
      @(posedge REF_CLK) disable iff (RESET) (rd_end && !underwrite) |=> !ERROR_FLAG_OUT;
   endproperty
   a_err_clear: assert property (p_err_clear)
      else $error("error flag not cleared by read");

   property p_no_err32;
      @(posedge REF_CLK) disable iff (RESET) mode32 |-> !underwrite;
   endproperty
   a_no_err32: assert property (p_no_err32)
      else $error("underwrite flagged in 32-bit mode");

   property p_underwrite_flags;
      @(posedge REF_CLK) disable iff (RESET) underwrite |=> ERROR_FLAG_OUT && !ser_busy;
   endproperty
   a_underwrite_flags: assert property (p_underwrite_flags)
      else $error("underwrite not flagged");

   property p_suspend;
      @(posedge REF_CLK) disable iff (RESET) ERROR_FLAG_OUT |-> !start_go && !TX_READY_OUT;
   endproperty
   a_suspend: assert property (p_suspend)
      else $error("transmitter active while error set");

   property p_hold_off;
      @(posedge REF_CLK) disable iff (RESET) (SEND_HOLD || !tx_enable) |-> !start_go;
   endproperty
   a_hold_off: assert property (p_hold_off)
      else $error("start while held or disabled");

endmodule
`default_nettype wire

/* rtl/swt_pkg.sv */
package swt_pkg;

   // control word layout
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_TEST_BIT = 4;
   localparam int CTRL_PARITY_BIT = 5;
   localparam logic [7:0] CTRL_RESET_VALUE = 8'h25;

   // status word layout; unlisted bits read as zero
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_IDLE_BIT = 2;
   localparam int STAT_ERROR_BIT = 7;

   // word framing
   localparam int WORD_BITS = 32;
   localparam int BYTE_BITS = 8;
   localparam int WORD_BYTES = 4;
   localparam logic [4:0] LAST_BIT_IDX = 5'h1f;
   localparam logic [2:0] LAST_BIT_IN_BYTE = 3'h7;
   localparam logic [2:0] FULL_COUNT = 3'h4;

   // timing in transmit clock periods
   localparam int TICKS_PER_BIT = 4;
   localparam int TICKS_PER_HALF = TICKS_PER_BIT / 2;
   localparam int GAP_BIT_TIMES = 4;
   localparam int GAP_TICKS = GAP_BIT_TIMES * TICKS_PER_BIT;
   localparam logic [3:0] GAP_LAST_TICK = 4'(GAP_TICKS - 1);

   typedef enum logic [1:0] {
      SWT_IDLE = 2'b00,
      SWT_PULSE = 2'b01,
      SWT_NULL = 2'b11,
      SWT_GAP = 2'b10
   } swt_state_e;

   // 32-bit buffer only with mode pin high and parity bit low
   function automatic logic word_mode32(input logic mode_pin, input logic par_bit);
      word_mode32 = mode_pin & ~par_bit;
   endfunction

   function automatic logic parity_on(input logic mode_pin, input logic par_bit);
      parity_on = mode_pin | par_bit;
   endfunction

endpackage

/* rtl/swt_host_port.sv */
`timescale 1ns/1ps
`default_nettype none
module swt_host_port (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic we_n,
   input wire logic re_n,
   input wire logic cmd_sel,
   input wire logic [7:0] status,
   output logic ctrl_wr,
   output logic data_wr,
   output logic rd_end,
   output logic rd_active,
   output logic [7:0] d_out,
   output logic d_oe
);
   logic we_n_reg;
   logic rd_reg;
   logic [7:0] d_out_reg;
   wire wr_edge = we_n_reg & ~we_n & ~cs_n;
   wire rd_now = ~cs_n & ~re_n & cmd_sel;

   assign ctrl_wr = wr_edge & cmd_sel;
   assign data_wr = wr_edge & ~cmd_sel;
   // error clear happens at the end of the read so the flag is seen first
   assign rd_end = rd_reg & ~rd_now;
   assign rd_active = rd_now;
   assign d_out = d_out_reg;
   assign d_oe = rd_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         we_n_reg <= 1'b1;
         rd_reg <= 1'b0;
         d_out_reg <= 8'h00;
      end else begin
         we_n_reg <= we_n;
         rd_reg <= rd_now;
         if (rd_now) begin
            d_out_reg <= status;
         end
      end
   end
endmodule
`default_nettype wire

/* rtl/swt_serializer.sv */
`timescale 1ns/1ps
`default_nettype none
module swt_serializer (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic start,
   input wire logic abort,
   input wire logic cur_bit,
   input wire logic quiet,
   output logic busy,
   output logic ready_to_start,
   output logic bit_end,
   output logic done,
   output logic [4:0] bit_idx,
   output logic zero_line,
   output logic one_line
);
   swt_pkg::swt_state_e state_reg, state_next;
   logic half_reg;
   logic [4:0] idx_reg;
   logic [3:0] gap_reg;
   logic zero_reg;
   logic one_reg;
   wire half_end = tick & half_reg;

   assign busy = (state_reg == swt_pkg::SWT_PULSE) | (state_reg == swt_pkg::SWT_NULL);
   assign ready_to_start = state_reg == swt_pkg::SWT_IDLE;
   assign bit_end = half_end & (state_reg == swt_pkg::SWT_NULL);
   assign done = bit_end & (idx_reg == swt_pkg::LAST_BIT_IDX);
   assign bit_idx = idx_reg;
   assign zero_line = zero_reg;
   assign one_line = one_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         swt_pkg::SWT_IDLE: if (start) state_next = swt_pkg::SWT_PULSE;
         swt_pkg::SWT_PULSE: if (half_end) state_next = swt_pkg::SWT_NULL;
         swt_pkg::SWT_NULL: begin
            if (done) state_next = swt_pkg::SWT_GAP;
            else if (half_end) state_next = swt_pkg::SWT_PULSE;
         end
         swt_pkg::SWT_GAP: begin
            if (tick && gap_reg == swt_pkg::GAP_LAST_TICK) state_next = swt_pkg::SWT_IDLE;
         end
      endcase
      if (abort) state_next = swt_pkg::SWT_IDLE;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= swt_pkg::SWT_IDLE;
         half_reg <= 1'b0;
         idx_reg <= 5'h00;
         gap_reg <= 4'h0;
         zero_reg <= 1'b0;
         one_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         // two ticks per half bit, four per bit
         half_reg <= (state_reg == swt_pkg::SWT_IDLE) ? 1'b0 : half_reg ^ tick;
         if (start && state_reg == swt_pkg::SWT_IDLE) idx_reg <= 5'h00;
         else if (bit_end && !done) idx_reg <= idx_reg + 5'h01;
         gap_reg <= (state_reg == swt_pkg::SWT_GAP) ? gap_reg + {3'h0, tick} : 4'h0;
         // only the pulse half drives a line; the rest is null
         zero_reg <= (state_reg == swt_pkg::SWT_PULSE) & ~cur_bit & ~quiet;
         one_reg <= (state_reg == swt_pkg::SWT_PULSE) & cur_bit & ~quiet;
      end
   end
endmodule
`default_nettype wire

/* dv/swt_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module swt_host_model (
   input wire logic clk,
   input wire logic [7:0] data_out,
   output logic cs_n,
   output logic we_n,
   output logic re_n,
   output logic cmd_sel,
   output logic [7:0] data_in
);
   initial begin
      cs_n = 1'b1;
      we_n = 1'b1;
      re_n = 1'b1;
      cmd_sel = 1'b1;
      data_in = 8'h5a;
   end

   // one write per call; strobe high again for a full cycle before the next
   task automatic wr(input logic cd, input logic [7:0] d);
      @(negedge clk);
      cs_n = 1'b0;
      cmd_sel = cd;
      data_in = d;
      we_n = 1'b0;
      @(negedge clk);
      we_n = 1'b1;
      cs_n = 1'b1;
      // released bus shows a changed value, not the stale byte
      data_in = ~d;
   endtask

   // status read: answer is registered, so taken two edges
   task automatic rd(output logic [7:0] s);
      @(negedge clk);
      cs_n = 1'b0;
      cmd_sel = 1'b1;
      re_n = 1'b0;
      @(negedge clk);
      @(negedge clk);
      s = data_out;
      re_n = 1'b1;
      cs_n = 1'b1;
   endtask
endmodule
`default_nettype wire

/* dv/tb_serial_word_transmitter_8bit_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_word_transmitter_8bit_port;
   logic ref_clk;
   logic rst = 1'b1;
   logic tx_bit_clock_4x = 1'b0;
   logic mode_pin = 1'b0;
   logic hold = 1'b0;
   wire logic cs_n;
   wire logic we_n;
   wire logic re_n;
   wire logic cmd_sel;
   wire logic [7:0] din;
   logic [7:0] dout;
   logic doe, rdy, idl, err, zl, ol, zl_q, ol_q;
   logic [31:0] cap_w;
   int cap_n = 0;
   int both_hi = 0;
   int tc = 0;
   int errors = 0;
   int tests_run = 0;

   swt_transmitter dut (.REF_CLK(ref_clk), .RESET(rst), .TX_BIT_CLOCK_4X(tx_bit_clock_4x),
      .WORD_MODE_PIN(mode_pin), .SEND_HOLD(hold), .CHIP_SELECT_N(cs_n),
      .WRITE_STROBE_N(we_n), .READ_STROBE_N(re_n), .CMD_DATA_SEL(cmd_sel),
      .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .TX_READY_OUT(rdy),
      .TX_IDLE_OUT(idl), .ERROR_FLAG_OUT(err), .ZERO_LINE_OUT(zl), .ONE_LINE_OUT(ol));

   swt_host_model h (.clk(ref_clk), .data_out(dout), .cs_n(cs_n), .we_n(we_n),
      .re_n(re_n), .cmd_sel(cmd_sel), .data_in(din));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // transmit clock at an eighth of the system clock
   always @(negedge ref_clk) begin
      tc <= tc + 1;
      if (tc % 4 == 3) tx_bit_clock_4x <= ~tx_bit_clock_4x;
   end

   // every rising edge of a line is one bit
   always @(posedge ref_clk) begin
      zl_q <= zl;
      ol_q <= ol;
      if (zl === 1'b1 && ol === 1'b1) both_hi <= both_hi + 1;
      if (zl === 1'b1 && zl_q !== 1'b1) begin
         cap_w[cap_n] <= 1'b0;
         cap_n <= cap_n + 1;
      end else if (ol === 1'b1 && ol_q !== 1'b1) begin
         cap_w[cap_n] <= 1'b1;
         cap_n <= cap_n + 1;
      end
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: pick = rdy;
         1: pick = idl;
         default: pick = err;
      endcase
   endfunction

   // bounded wait on ready (0), idle (1) or error (2)
   task automatic waitv(input int s, input logic v, input int lim);
      int n;
      n = 0;
      while (pick(s) !== v && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      chk($sformatf("wait on %0d", s), 32'(v), 32'(pick(s)));
   endtask

   task automatic t_reset;
      logic [7:0] st;
      h.rd(st);
      chk("status after reset", 32'h05, 32'(st));
      chk("drive during read", 32'h1, 32'(doe));
      chk("lines at rest", 32'h0, {30'h0, zl, ol});
      $display("done: reset state");
   endtask

   // loads one word in the mode picked by the pin and control byte, then checks the line
   task automatic send_word(input logic [7:0] ctrl, input logic [31:0] w, input logic hl);
      logic [31:0] e;
      logic m32;
      int k;
      m32 = mode_pin & ~ctrl[5];
      e = w;
      if (mode_pin | ctrl[5]) e[31] = ~^w[30:0];
      @(negedge ref_clk);
      cap_n = 0;
      both_hi = 0;
      hold = hl;
      if (m32) begin
         h.wr(1'b1, ctrl & 8'hfe);
         for (k = 0; k < 4; k++) begin
            waitv(0, 1'b1, 10);
            h.wr(1'b0, w[8*k+:8]);
         end
         waitv(0, 1'b0, 3);
         repeat (40) @(negedge ref_clk);
         chk("idle before enable", 32'h1, 32'(idl));
         h.wr(1'b1, ctrl | 8'h01);
         if (hl) begin
            repeat (60) @(negedge ref_clk);
            chk("idle under hold", 32'h1, 32'(idl));
            hold = 1'b0;
         end
      end else begin
         h.wr(1'b1, ctrl);
         for (k = 0; k < 4; k++) begin
            waitv(0, 1'b1, 1500);
            h.wr(1'b0, w[8*k+:8]);
            waitv(0, 1'b0, 3);
         end
      end
      waitv(1, 1'b0, 300);
      waitv(1, 1'b1, 1500);
      chk("bits sent", ctrl[4] ? 32'h0 : 32'd32, 32'(cap_n));
      if (!ctrl[4]) chk("word sent", e, cap_w);
      chk("both lines high", 32'h0, 32'(both_hi));
      chk("error after word", 32'h0, 32'(err));
      $display("done: word mode %b ctrl %h", mode_pin, ctrl);
   endtask

   task automatic t_underwrite;
      logic [7:0] st;
      mode_pin = 1'b0;
      h.wr(1'b1, 8'h21);
      waitv(0, 1'b1, 200);
      h.wr(1'b0, 8'ha5);
      waitv(2, 1'b1, 600);
      repeat (50) @(negedge ref_clk);
      chk("ready while error", 32'h0, 32'(rdy));
      chk("error held", 32'h1, 32'(err));
      h.rd(st);
      chk("status error bit", 32'h1, 32'(st[7]));
      repeat (2) @(negedge ref_clk);
      chk("error after read", 32'h0, 32'(err));
      waitv(0, 1'b1, 200);
      $display("done: underwrite");
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      $display("MISMATCH watchdog expected end seen timeout");
      finish_test;
   end

   initial begin
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
      repeat (2) @(negedge ref_clk);
      t_reset;
      send_word(8'h01, 32'h8123_4567, 1'b0);
      send_word(8'h21, 32'h0000_00ff, 1'b0);
      mode_pin = 1'b1;
      send_word(8'h00, 32'h7e5a_c3a1, 1'b1);
      send_word(8'h21, 32'hffff_fffe, 1'b0);
      send_word(8'h10, 32'h1234_5678, 1'b0);
      t_underwrite;
      finish_test;
   end
endmodule
`default_nettype wire
